/* event_route_if.sv */
`timescale 1ns/1ns
`default_nettype none
interface event_route_if
   import event_unit_pkg::*;
   ();
   event_vec_t trigger;
   chan_vec_t send_mask [NUM_TASKS];
   chan_vec_t fire_out;
   chan_vec_t fire_in;
   chan_vec_t recv_mask [NUM_EVENTS];
   event_vec_t hit;

   modport owner (output trigger, output send_mask, output fire_in, output recv_mask,
                  input fire_out, input hit);
   modport fanout (input trigger, input send_mask, output fire_out);
   modport matcher (input fire_in, input recv_mask, output hit);
endinterface
`default_nettype wire

/* event_unit_pkg.sv */
package event_unit_pkg;

   // ---------------------------------------------------------------------------
   // Sizes
   // ---------------------------------------------------------------------------
   localparam int NUM_TASKS = 16;
   localparam int NUM_EVENTS = 16;
   localparam int NUM_CHANNELS = 16;
   localparam int NUM_IC_CHANNELS = 16;
   localparam int NUM_SCRATCH = 2;
   localparam int ADDR_W = 12;
   localparam int DATA_W = 32;
   localparam int IDX_LSB = 2;
   localparam int IDX_W = 4;
   localparam int SCRATCH_IDX_W = 1;
   localparam int HOOK_CHAN_W = 4;

   typedef logic [ADDR_W-1:0] addr_t;
   typedef logic [DATA_W-1:0] data_t;
   typedef logic [IDX_W-1:0] idx_t;
   typedef logic [NUM_CHANNELS-1:0] chan_vec_t;
   typedef logic [NUM_EVENTS-1:0] event_vec_t;
   typedef logic [NUM_IC_CHANNELS-1:0] ic_vec_t;
   typedef logic [HOOK_CHAN_W-1:0] hook_chan_t;

   // ---------------------------------------------------------------------------
   // Register map
   // ---------------------------------------------------------------------------
   localparam addr_t OFS_SEND_TRIGGER = 12'h000;
   localparam addr_t OFS_SUBSCRIBE = 12'h080;
   localparam addr_t OFS_EVENT_FLAG = 12'h100;
   localparam addr_t OFS_PUBLISH = 12'h180;
   localparam addr_t OFS_IRQ_ENABLE = 12'h300;
   localparam addr_t OFS_IRQ_SET = 12'h304;
   localparam addr_t OFS_IRQ_CLEAR = 12'h308;
   localparam addr_t OFS_IRQ_PENDING = 12'h30C;
   localparam addr_t OFS_SEND_MASK = 12'h510;
   localparam addr_t OFS_RECV_MASK = 12'h590;
   localparam addr_t OFS_SCRATCH = 12'h610;
   localparam addr_t ARRAY_SPAN = 12'h040;
   localparam addr_t SCRATCH_SPAN = 12'h008;
   localparam addr_t WORD_SPAN = 12'h004;

   // ---------------------------------------------------------------------------
   // Fields and reset values
   // ---------------------------------------------------------------------------
   localparam int TRIGGER_BIT = 0;
   localparam int FLAG_BIT = 0;
   localparam int HOOK_EN_BIT = 31;
   localparam data_t RESET_WORD = 32'h0000_0000;

endpackage

/* event_unit_sva.sv */
`timescale 1ns/1ns
`default_nettype none
module event_unit_sva
   import event_unit_pkg::*;
   (
   input wire logic I_CORE_CLK,
   input wire logic I_SYS_RST,
   input wire logic [ADDR_W-1:0] I_ADDR,
   input wire logic [DATA_W-1:0] I_WDATA,
   input wire logic I_WR,
   input wire logic I_RD,
   input wire logic [DATA_W-1:0] O_RDATA,
   input wire logic O_IRQ,
   input wire logic [NUM_CHANNELS-1:0] I_CHAN_FIRE,
   input wire logic [NUM_CHANNELS-1:0] O_CHAN_FIRE,
   input wire logic [NUM_IC_CHANNELS-1:0] I_IC_EVENT,
   input wire logic [NUM_IC_CHANNELS-1:0] O_IC_EVENT
   );
   default clocking cb @(posedge I_CORE_CLK);
   endclocking
   default disable iff (I_SYS_RST);
   a_rdata_idle_zero: assert property (!I_RD |=> O_RDATA == '0)
      else $error("read data not zero outside read slot");
   a_fire_has_cause: assert property (O_CHAN_FIRE != '0 |->
      ($past(I_WR) && $past(I_ADDR) < ARRAY_SPAN) || $past(I_IC_EVENT) != '0)
      else $error("channel fired without trigger");
   a_enable_load_off: assert property (I_WR && I_ADDR == OFS_IRQ_ENABLE
      && I_WDATA[15:0] == '0 |=> ##1 !O_IRQ)
      else $error("irq high after enable cleared");
   a_enable_clear_off: assert property (I_WR && I_ADDR == OFS_IRQ_CLEAR
      && I_WDATA[15:0] == 16'hFFFF |=> ##1 !O_IRQ)
      else $error("irq high after clear of all enables");
   a_set_reads_back: assert property (I_WR && I_ADDR == OFS_IRQ_SET
      ##1 I_RD && I_ADDR == OFS_IRQ_ENABLE
      |=> (O_RDATA[15:0] & $past(I_WDATA[15:0], 2)) == $past(I_WDATA[15:0], 2))
      else $error("set bits missing from enable");
   a_pending_gated: assert property (I_WR && I_ADDR == OFS_IRQ_ENABLE
      && I_WDATA[15:0] == '0 ##1 I_RD && I_ADDR == OFS_IRQ_PENDING |=> O_RDATA == '0)
      else $error("pending set with enables off");
   a_scratch_holds: assert property (I_WR && (I_ADDR == 12'h610 || I_ADDR == 12'h614)
      ##1 I_RD && I_ADDR == $past(I_ADDR) |=> O_RDATA == $past(I_WDATA, 2))
      else $error("scratch word lost its value");
   a_mask_holds: assert property (I_WR && I_ADDR[1:0] == 2'b00
      && ((I_ADDR - OFS_SEND_MASK) < ARRAY_SPAN || (I_ADDR - OFS_RECV_MASK) < ARRAY_SPAN)
      ##1 I_RD && I_ADDR == $past(I_ADDR) |=> O_RDATA[15:0] == $past(I_WDATA[15:0], 2))
      else $error("channel mask lost its value");
   a_empty_read_zero: assert property (I_RD && (I_ADDR < ARRAY_SPAN
      || I_ADDR == 12'h7FC || I_ADDR[1:0] != 2'b00) |=> O_RDATA == '0)
      else $error("trigger or unmapped read not zero");
   c_chan_rise: cover property ($rose(|I_CHAN_FIRE));
   c_ic_publish: cover property (O_IC_EVENT != '0);
endmodule // event_unit_sva
bind interprocessor_event_unit event_unit_sva i_event_unit_sva (.I_CORE_CLK, .I_SYS_RST,
   .I_ADDR, .I_WDATA, .I_WR, .I_RD, .O_RDATA, .O_IRQ, .I_CHAN_FIRE, .O_CHAN_FIRE,
   .I_IC_EVENT, .O_IC_EVENT);
`default_nettype wire

/* interprocessor_event_unit.sv */
// Contract
// RULE_01 - Sixteen send tasks fire their masked channels
// RULE_02 - Subscribe words let interconnect trigger tasks
// RULE_03 - Receive flag sets on any subscribed channel
// RULE_04 - Publish words forward receive events outward
// RULE_05 - Enable word, one bit per event, reset zero
// RULE_06 - Enable-set writes ones, reads enable state
// RULE_07 - Enable-clear clears ones, reads enable state
// RULE_08 - Pending word shows pending events, read-only
// RULE_09 - Sixteen send channel masks, read-write
// RULE_10 - Sixteen receive channel masks, read-write
// RULE_11 - Two scratch words, plain storage, no effects
// RULE_12 - Same-channel firings inside window may merge
// RULE_13 - Scratch words private to this instance
// RULE_14 - Every mask has a bit per channel
// RULE_15 - Interrupt while flag and enable both set
// RULE_16 - Flag stays until software clears it
//
// Implementation choice: strobed register access.
`timescale 1ns/1ns
`default_nettype none
module interprocessor_event_unit
   import event_unit_pkg::*;
   (
   input wire logic I_CORE_CLK,
   input wire logic I_SYS_RST,
   input wire logic [ADDR_W-1:0] I_ADDR,
   input wire logic [DATA_W-1:0] I_WDATA,
   input wire logic I_WR,
   input wire logic I_RD,
   output logic [DATA_W-1:0] O_RDATA,
   output logic O_IRQ,
   input wire logic [NUM_CHANNELS-1:0] I_CHAN_FIRE,
   output logic [NUM_CHANNELS-1:0] O_CHAN_FIRE,
   input wire logic [NUM_IC_CHANNELS-1:0] I_IC_EVENT,
   output logic [NUM_IC_CHANNELS-1:0] O_IC_EVENT
   );

   // ---------------------------------------------------------------------------
   // Address decode
   // ---------------------------------------------------------------------------
   // Unaligned addresses match no region, so such reads return zero and writes are dropped.
   function automatic logic in_region(input addr_t a, input addr_t base, input addr_t span);
      in_region = (a >= base) && (a < addr_t'(base + span)) && (a[IDX_LSB-1:0] == '0);
   endfunction

   function automatic idx_t region_index(input addr_t a, input addr_t base);
      addr_t rel;
      rel = addr_t'(a - base);
      region_index = rel[IDX_LSB +: IDX_W];
   endfunction

   logic sel_trigger;
   logic sel_subscribe;
   logic sel_flag;
   logic sel_publish;
   logic sel_enable;
   logic sel_set;
   logic sel_clear;
   logic sel_pending;
   logic sel_send_mask;
   logic sel_recv_mask;
   logic sel_scratch;
   idx_t bus_idx;

   always_comb begin
      sel_trigger = in_region(I_ADDR, OFS_SEND_TRIGGER, ARRAY_SPAN);
      sel_subscribe = in_region(I_ADDR, OFS_SUBSCRIBE, ARRAY_SPAN);
      sel_flag = in_region(I_ADDR, OFS_EVENT_FLAG, ARRAY_SPAN);
      sel_publish = in_region(I_ADDR, OFS_PUBLISH, ARRAY_SPAN);
      sel_enable = in_region(I_ADDR, OFS_IRQ_ENABLE, WORD_SPAN);
      sel_set = in_region(I_ADDR, OFS_IRQ_SET, WORD_SPAN);
      sel_clear = in_region(I_ADDR, OFS_IRQ_CLEAR, WORD_SPAN);
      sel_pending = in_region(I_ADDR, OFS_IRQ_PENDING, WORD_SPAN);
      sel_send_mask = in_region(I_ADDR, OFS_SEND_MASK, ARRAY_SPAN);
      sel_recv_mask = in_region(I_ADDR, OFS_RECV_MASK, ARRAY_SPAN);
      sel_scratch = in_region(I_ADDR, OFS_SCRATCH, SCRATCH_SPAN);
      if (sel_subscribe) begin
         bus_idx = region_index(I_ADDR, OFS_SUBSCRIBE);
      end else if (sel_flag) begin
         bus_idx = region_index(I_ADDR, OFS_EVENT_FLAG);
      end else if (sel_publish) begin
         bus_idx = region_index(I_ADDR, OFS_PUBLISH);
      end else if (sel_send_mask) begin
         bus_idx = region_index(I_ADDR, OFS_SEND_MASK);
      end else if (sel_recv_mask) begin
         bus_idx = region_index(I_ADDR, OFS_RECV_MASK);
      end else if (sel_scratch) begin
         bus_idx = region_index(I_ADDR, OFS_SCRATCH);
      end else begin
         bus_idx = region_index(I_ADDR, OFS_SEND_TRIGGER);
      end
   end

   // ---------------------------------------------------------------------------
   // Access strobes
   // ---------------------------------------------------------------------------
   logic wr_trigger;
   logic wr_subscribe;
   logic wr_flag;
   logic wr_publish;
   logic wr_enable;
   logic wr_set;
   logic wr_clear;
   logic wr_send_mask;
   logic wr_recv_mask;
   logic wr_scratch;
   logic rd_flag;

   // Writes to the pending word decode to no strobe, so they are ignored.
   always_comb begin
      wr_trigger = I_WR && sel_trigger;
      wr_subscribe = I_WR && sel_subscribe;
      wr_flag = I_WR && sel_flag;
      wr_publish = I_WR && sel_publish;
      wr_enable = I_WR && sel_enable;
      wr_set = I_WR && sel_set;
      wr_clear = I_WR && sel_clear;
      wr_send_mask = I_WR && sel_send_mask;
      wr_recv_mask = I_WR && sel_recv_mask;
      wr_scratch = I_WR && sel_scratch;
      rd_flag = I_RD && sel_flag;
   end

   // ---------------------------------------------------------------------------
   // Configuration storage
   // ---------------------------------------------------------------------------
   chan_vec_t send_mask [NUM_TASKS];
   chan_vec_t recv_mask [NUM_EVENTS];
   logic [NUM_TASKS-1:0] sub_en;
   hook_chan_t sub_chan [NUM_TASKS];
   logic [NUM_EVENTS-1:0] pub_en;
   hook_chan_t pub_chan [NUM_EVENTS];
   data_t scratch [NUM_SCRATCH];
   event_vec_t irq_enable;

   // Masks and hook words reset to zero, so nothing fires until software sets them up.
   always_ff @(posedge I_CORE_CLK) begin
      if (I_SYS_RST) begin
         for (int i = 0; i < NUM_TASKS; i++) begin
            send_mask[i] <= '0;
            sub_chan[i] <= '0;
         end
         sub_en <= '0;
      end else begin
         if (wr_send_mask) begin
            send_mask[bus_idx] <= I_WDATA[NUM_CHANNELS-1:0]; // [RULE_09] [RULE_14]
         end
         if (wr_subscribe) begin
            sub_en[bus_idx] <= I_WDATA[HOOK_EN_BIT]; // [RULE_02]
            sub_chan[bus_idx] <= I_WDATA[HOOK_CHAN_W-1:0]; // [RULE_02]
         end
      end
   end

   always_ff @(posedge I_CORE_CLK) begin
      if (I_SYS_RST) begin
         for (int i = 0; i < NUM_EVENTS; i++) begin
            recv_mask[i] <= '0;
            pub_chan[i] <= '0;
         end
         pub_en <= '0;
      end else begin
         if (wr_recv_mask) begin
            recv_mask[bus_idx] <= I_WDATA[NUM_CHANNELS-1:0]; // [RULE_10] [RULE_14]
         end
         if (wr_publish) begin
            pub_en[bus_idx] <= I_WDATA[HOOK_EN_BIT]; // [RULE_04]
            pub_chan[bus_idx] <= I_WDATA[HOOK_CHAN_W-1:0]; // [RULE_04]
         end
      end
   end

   // Scratch storage is local flip-flops, so no other instance can see it.
   always_ff @(posedge I_CORE_CLK) begin
      if (I_SYS_RST) begin
         for (int i = 0; i < NUM_SCRATCH; i++) begin
            scratch[i] <= RESET_WORD;
         end
      end else if (wr_scratch) begin
         scratch[bus_idx[SCRATCH_IDX_W-1:0]] <= I_WDATA; // [RULE_11] [RULE_13]
      end
   end

   always_ff @(posedge I_CORE_CLK) begin
      if (I_SYS_RST) begin
         irq_enable <= RESET_WORD[NUM_EVENTS-1:0]; // [RULE_05]
      end else if (wr_enable) begin
         irq_enable <= I_WDATA[NUM_EVENTS-1:0]; // [RULE_05]
      end else if (wr_set) begin
         irq_enable <= irq_enable | I_WDATA[NUM_EVENTS-1:0]; // [RULE_06]
      end else if (wr_clear) begin
         irq_enable <= irq_enable & ~I_WDATA[NUM_EVENTS-1:0]; // [RULE_07]
      end
   end

   // ---------------------------------------------------------------------------
   // Channel input synchroniser and firing detect
   // ---------------------------------------------------------------------------
   chan_vec_t chan_meta;
   chan_vec_t chan_sync;
   chan_vec_t chan_prev;

   // A firing is a rising level; firings closer than the synchroniser can
   // resolve merge into one, which is the merge window seen by this receiver.
   always_ff @(posedge I_CORE_CLK) begin
      if (I_SYS_RST) begin
         chan_meta <= '0;
         chan_sync <= '0;
         chan_prev <= '0;
      end else begin
         chan_meta <= I_CHAN_FIRE;
         chan_sync <= chan_meta;
         chan_prev <= chan_sync; // [RULE_12]
      end
   end

   // ---------------------------------------------------------------------------
   // Routing
   // ---------------------------------------------------------------------------
   event_route_if route ();
   event_vec_t trigger;
   event_vec_t hit;
   chan_vec_t fire_out;

   // Interconnect pulses share this clock, so the hooks read them without a synchroniser.
   for (genvar t = 0; t < NUM_TASKS; t++) begin : g_trigger
      assign trigger[t] = (wr_trigger && (bus_idx == idx_t'(t))
                           && I_WDATA[TRIGGER_BIT]) // [RULE_01]
                          || (sub_en[t] && I_IC_EVENT[sub_chan[t]]); // [RULE_02]
   end

   assign route.trigger = trigger;
   assign route.fire_in = chan_sync & ~chan_prev;
   for (genvar t = 0; t < NUM_TASKS; t++) begin : g_send_mask
      assign route.send_mask[t] = send_mask[t];
   end
   for (genvar e = 0; e < NUM_EVENTS; e++) begin : g_recv_mask
      assign route.recv_mask[e] = recv_mask[e];
   end
   assign fire_out = route.fire_out;
   assign hit = route.hit;

   send_fanout i_send_fanout (
      .route(route.fanout)
   );

   receive_match i_receive_match (
      .route(route.matcher)
   );

   // ---------------------------------------------------------------------------
   // Receive flags
   // ---------------------------------------------------------------------------
   event_vec_t flag;
   event_vec_t flag_clr;
   event_vec_t pending;

   // A read of a flag word clears it, as a read-to-clear status bit would.
   always_comb begin
      flag_clr = '0;
      if ((wr_flag && !I_WDATA[FLAG_BIT]) || rd_flag) begin
         flag_clr[bus_idx] = 1'b1;
      end
   end

   // A hit in the clearing cycle keeps the flag set.
   always_ff @(posedge I_CORE_CLK) begin
      if (I_SYS_RST) begin
         flag <= '0;
      end else begin
         flag <= (flag & ~flag_clr) | hit; // [RULE_03] [RULE_16]
      end
   end

   assign pending = flag & irq_enable; // [RULE_08] [RULE_15]

   // ---------------------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------------------
   ic_vec_t next_ic;

   always_comb begin
      next_ic = '0;
      for (int e = 0; e < NUM_EVENTS; e++) begin
         if (pub_en[e] && hit[e]) begin
            next_ic[pub_chan[e]] = 1'b1; // [RULE_04]
         end
      end
   end

   always_ff @(posedge I_CORE_CLK) begin
      if (I_SYS_RST) begin
         O_CHAN_FIRE <= '0;
         O_IC_EVENT <= '0;
         O_IRQ <= 1'b0;
      end else begin
         O_CHAN_FIRE <= fire_out; // [RULE_01]
         O_IC_EVENT <= next_ic;
         O_IRQ <= |pending; // [RULE_15]
      end
   end

   // ---------------------------------------------------------------------------
   // Read path
   // ---------------------------------------------------------------------------
   data_t next_rdata;

   always_comb begin
      next_rdata = RESET_WORD;
      if (sel_subscribe) begin
         next_rdata[HOOK_EN_BIT] = sub_en[bus_idx];
         next_rdata[HOOK_CHAN_W-1:0] = sub_chan[bus_idx];
      end else if (sel_flag) begin
         next_rdata[FLAG_BIT] = flag[bus_idx];
      end else if (sel_publish) begin
         next_rdata[HOOK_EN_BIT] = pub_en[bus_idx];
         next_rdata[HOOK_CHAN_W-1:0] = pub_chan[bus_idx];
      end else if (sel_enable || sel_set || sel_clear) begin
         next_rdata[NUM_EVENTS-1:0] = irq_enable; // [RULE_05] [RULE_06] [RULE_07]
      end else if (sel_pending) begin
         next_rdata[NUM_EVENTS-1:0] = pending; // [RULE_08]
      end else if (sel_send_mask) begin
         next_rdata[NUM_CHANNELS-1:0] = send_mask[bus_idx];
      end else if (sel_recv_mask) begin
         next_rdata[NUM_CHANNELS-1:0] = recv_mask[bus_idx];
      end else if (sel_scratch) begin
         next_rdata = scratch[bus_idx[SCRATCH_IDX_W-1:0]]; // [RULE_11]
      end
   end

   // Read data stand for one cycle only and are zero otherwise.
   always_ff @(posedge I_CORE_CLK) begin
      if (I_SYS_RST) begin
         O_RDATA <= RESET_WORD;
      end else if (I_RD) begin
         O_RDATA <= next_rdata;
      end else begin
         O_RDATA <= RESET_WORD;
      end
   end

endmodule // interprocessor_event_unit
`default_nettype wire

/* peer_event_model.sv */
`timescale 1ns/1ns
`default_nettype none
module peer_event_model
   import event_unit_pkg::*;
   #(parameter int HOLD = 3)
   (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic [NUM_CHANNELS-1:0] i_go,
   input wire logic [NUM_CHANNELS-1:0] i_unit_fire,
   output logic [NUM_CHANNELS-1:0] o_level,
   output var int o_fired
   );
   int cnt [NUM_CHANNELS];
   // A channel stays high HOLD cycles, then low HOLD more; requests while busy are dropped.
   always_ff @(posedge i_clk) begin
      for (int c = 0; c < NUM_CHANNELS; c++) begin
         if (i_rst || cnt[c] == 0) begin
            cnt[c] <= (!i_rst && i_go[c]) ? 2 * HOLD : 0;
         end else begin
            cnt[c] <= cnt[c] - 1;
         end
      end
   end
   always_ff @(posedge i_clk) begin
      o_fired <= i_rst ? 0 : o_fired + $countones(i_unit_fire);
   end
   always_comb begin
      for (int c = 0; c < NUM_CHANNELS; c++) begin
         o_level[c] = cnt[c] > HOLD;
      end
   end
endmodule // peer_event_model
`default_nettype wire

/* receive_match.sv */
`timescale 1ns/1ns
`default_nettype none
module receive_match
   import event_unit_pkg::*;
   (
   event_route_if.matcher route
   );

   // An event is hit when any fired channel is enabled in its mask.
   for (genvar e = 0; e < NUM_EVENTS; e++) begin : g_event
      assign route.hit[e] = |(route.fire_in & route.recv_mask[e]); // [RULE_03] [RULE_14]
   end

endmodule // receive_match
`default_nettype wire

/* send_fanout.sv */
`timescale 1ns/1ns
`default_nettype none
module send_fanout
   import event_unit_pkg::*;
   (
   event_route_if.fanout route
   );

   // A channel fires when any triggered task has that channel in its mask.
   for (genvar c = 0; c < NUM_CHANNELS; c++) begin : g_chan
      logic [NUM_TASKS-1:0] column;
      for (genvar t = 0; t < NUM_TASKS; t++) begin : g_task
         assign column[t] = route.trigger[t] & route.send_mask[t][c]; // [RULE_01] [RULE_14]
      end
      assign route.fire_out[c] = |column;
   end

endmodule // send_fanout
`default_nettype wire

/* tb_interprocessor_event_unit.sv */
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin miscompares++; \
   $display("BAD t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb_interprocessor_event_unit
   import event_unit_pkg::*;
   ();
   logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, irq, chk_en = 1'b0;
   addr_t addr = '0;
   data_t wdata = '0, rdata, chk_val = '0, rexp = '0, d;
   data_t sub [16], pub [16];
   chan_vec_t cin, cout, xfire, go = '0;
   chan_vec_t smask [16], rmask [16];
   ic_vec_t icin = '0, icout, seen, xic;
   event_vec_t en = '0, fl = '0;
   int miscompares = 0, checks_done = 0, total = 0, fired;
   logic [31:0] seed = 32'hD871CE3A;
   addr_t bases [5] = '{OFS_SUBSCRIBE, OFS_EVENT_FLAG, OFS_PUBLISH, OFS_SEND_MASK, OFS_RECV_MASK};
   interprocessor_event_unit i_interprocessor_event_unit (.I_CORE_CLK(clk), .I_SYS_RST(rst),
      .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr), .I_RD(rd), .O_RDATA(rdata), .O_IRQ(irq),
      .I_CHAN_FIRE(cin), .O_CHAN_FIRE(cout), .I_IC_EVENT(icin), .O_IC_EVENT(icout));
   peer_event_model i_peer_event_model (.i_clk(clk), .i_rst(rst), .i_go(go), .i_unit_fire(cout),
      .o_level(cin), .o_fired(fired));
   initial begin
      forever #10 clk = ~clk;
   end
   function automatic data_t rnd();
      seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
      return seed;
   endfunction
   function automatic addr_t at(input addr_t b, input int i);
      return b + addr_t'(4 * i);
   endfunction
   task automatic wr_reg(input addr_t a, input data_t v);
      wr <= 1'b1;
      rd <= 1'b0;
      addr <= a;
      wdata <= v;
      @(posedge clk);
   endtask
   task automatic rd_reg(input addr_t a, input data_t e);
      wr <= 1'b0;
      rd <= 1'b1;
      addr <= a;
      rexp <= e;
      @(posedge clk);
   endtask
   task automatic wr_rd(input addr_t a, input data_t v, input data_t m);
      wr_reg(a, v);
      rd_reg(a, v & m);
   endtask
   task automatic idle(input int n);
      wr <= 1'b0;
      rd <= 1'b0;
      repeat (n) @(posedge clk);
   endtask
   task automatic results();
      $display("checks %0d mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   // Read data is compared one edge after the strobe, before that edge's updates land.
   always @(posedge clk) begin
      if (chk_en) `CHK(rdata, chk_val)
      chk_en <= rd;
      chk_val <= rexp;
   end
   initial begin
      repeat (30000) @(posedge clk);
      miscompares++;
      results();
   end
   initial begin
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      idle(1);
      for (int j = 0; j < 5; j++) begin
         for (int i = 0; i < 16; i++) rd_reg(at(bases[j], i), RESET_WORD);
      end
      for (int i = 0; i < 6; i++) begin
         rd_reg(i < 4 ? at(OFS_IRQ_ENABLE, i) : at(OFS_SCRATCH, i - 4), RESET_WORD);
      end
      $display("test reset_values done");
      for (int i = 0; i < 16; i++) begin
         d = rnd();
         smask[i] = d[15:0];
         wr_rd(at(OFS_SEND_MASK, i), d, 32'h0000_FFFF);
         d = rnd();
         rmask[i] = d[15:0];
         wr_rd(at(OFS_RECV_MASK, i), d, 32'h0000_FFFF);
         d = rnd();
         sub[i] = d & 32'h8000_000F;
         wr_rd(at(OFS_SUBSCRIBE, i), d, 32'h8000_000F);
         d = rnd();
         pub[i] = d & 32'h8000_000F;
         wr_rd(at(OFS_PUBLISH, i), d, 32'h8000_000F);
         if (i < 2) wr_rd(at(OFS_SCRATCH, i), rnd(), 32'hFFFF_FFFF);
      end
      wr_rd(12'h7FC, rnd(), RESET_WORD);
      rd_reg(12'h302, RESET_WORD);
      rd_reg(OFS_SEND_TRIGGER, RESET_WORD);
      d = rnd();
      en = d[15:0];
      wr_rd(OFS_IRQ_ENABLE, d, 32'h0000_FFFF);
      d = rnd();
      en = en | d[15:0];
      wr_reg(OFS_IRQ_SET, d);
      rd_reg(OFS_IRQ_ENABLE, {16'h0000, en});
      d = rnd();
      en = en & ~d[15:0];
      wr_reg(OFS_IRQ_CLEAR, d);
      rd_reg(OFS_IRQ_SET, {16'h0000, en});
      rd_reg(OFS_IRQ_CLEAR, {16'h0000, en});
      wr_reg(OFS_IRQ_PENDING, '1);
      rd_reg(OFS_IRQ_PENDING, RESET_WORD);
      $display("test registers done");
      for (int n = 0; n < 16; n++) begin
         wr_reg(at(OFS_SEND_TRIGGER, n), 32'h1);
         wr_reg(at(OFS_SEND_TRIGGER, n), 32'h0);
         `CHK(cout, smask[n])
         idle(1);
         `CHK(cout, '0)
         total += $countones(smask[n]);
      end
      for (int c = 0; c < 16; c++) begin
         xfire = '0;
         for (int n = 0; n < 16; n++) begin
            if (sub[n][31] && sub[n][3:0] == c) xfire |= smask[n];
         end
         icin <= ic_vec_t'(1) << c;
         @(posedge clk);
         icin <= '0;
         @(posedge clk);
         `CHK(cout, xfire)
         total += $countones(xfire);
      end
      idle(2);
      `CHK(fired, total)
      $display("test send done");
      for (int r = 0; r < 4; r++) begin
         if (r == 1) wr_reg(OFS_IRQ_CLEAR, 32'h0000_FFFF);
         if (r == 2) wr_reg(OFS_IRQ_SET, 32'h0000_FFFF);
         en = (r == 1) ? '0 : (r == 2) ? '1 : en;
         idle(1);
         d = rnd();
         go <= d[15:0];
         @(posedge clk);
         go <= '0;
         xic = '0;
         for (int n = 0; n < 16; n++) begin
            if ((rmask[n] & d[15:0]) != '0) begin
               fl[n] = 1'b1;
               if (pub[n][31]) xic[pub[n][3:0]] = 1'b1;
            end
         end
         seen = '0;
         repeat (10) begin
            @(posedge clk);
            seen |= icout;
         end
         `CHK(seen, xic)
         `CHK(irq, |(fl & en))
         rd_reg(OFS_IRQ_PENDING, {16'h0000, fl & en});
         if (r == 3) begin
            wr_reg(OFS_IRQ_ENABLE, RESET_WORD);
            rd_reg(OFS_IRQ_PENDING, RESET_WORD);
            en = '0;
         end
         wr_reg(at(OFS_EVENT_FLAG, r), RESET_WORD);
         wr_reg(at(OFS_EVENT_FLAG, r + 4), 32'h1);
         fl[r] = 1'b0;
         for (int n = 0; n < 16; n++) rd_reg(at(OFS_EVENT_FLAG, n), {31'h0, fl[n]});
         fl = '0;
         idle(3);
         `CHK(irq, 1'b0)
      end
      $display("test receive done");
      results();
   end
endmodule // tb_interprocessor_event_unit
`default_nettype wire
